// ==== include/spp_pkg.sv ====
// shared constants and types for the port pause / low-power-idle enable block
package spp_pkg;

  localparam int SPP_NUM_PORTS = 3;

  // port operating mode encoding
  typedef enum logic [2:0] {
    SPP_MODE_INT_PHY,
    SPP_MODE_MII_MAC,
    SPP_MODE_MII_PHY,
    SPP_MODE_RMII_MAC,
    SPP_MODE_RMII_PHY
  } spp_mode_type;

  // override register fields
  localparam int SPP_FLD_BP = 0;
  localparam int SPP_FLD_RX = 1;
  localparam int SPP_FLD_TX = 2;
  localparam int SPP_FLD_SEL = 3;
  localparam int SPP_FLD_LPI = 4;
  localparam int SPP_FLD_DUPLEX_ST = 5;
  localparam int SPP_FLD_RX_ST = 6;
  localparam int SPP_FLD_TX_ST = 7;
  localparam int SPP_REG_W = 8;

  // register indices
  localparam logic [3:0] SPP_ADDR_P0 = 4'h0;
  localparam logic [3:0] SPP_ADDR_P1 = 4'h4;
  localparam logic [3:0] SPP_ADDR_P2 = 4'h8;
  localparam logic [7:0] SPP_OVR_RESET = 8'h00;

  // link-up qualification time
  localparam int SPP_CLK_HZ = 40000000;
  localparam int SPP_LINK_UP_MS = 1000;
  localparam int SPP_LINK_UP_CYC = SPP_CLK_HZ / 1000 * SPP_LINK_UP_MS;

endpackage

// ==== logic/spp_pause_resolve.sv ====
// pause enable resolution for one port
`timescale 1ns/100ps
module spp_pause_resolve
  import spp_pkg::*;
(
  input wire logic full_duplex_in, // 1 = full duplex
  input wire logic an_enable_in, // negotiation enabled
  input wire logic an_complete_in, // negotiation done
  input wire logic lp_an_able_in, // partner can negotiate
  input wire logic loc_pause_in, // local symmetric pause
  input wire logic loc_asym_in, // local asymmetric pause
  input wire logic lp_pause_in, // partner symmetric pause
  input wire logic lp_asym_in, // partner asymmetric pause
  input wire logic [SPP_REG_W-1:0] ovr_in, // override register
  output logic rx_en_out, // receive pause enable
  output logic tx_en_out // transmit pause enable
);

  logic manual;
  logic [3:0] abil;

  always_comb begin
    manual = ovr_in[SPP_FLD_SEL] | ~an_enable_in;
    abil = {loc_pause_in, loc_asym_in, lp_pause_in, lp_asym_in};
    rx_en_out = 1'h0;
    tx_en_out = 1'h0;
    if (manual) begin
      if (full_duplex_in) begin
        rx_en_out = ovr_in[SPP_FLD_RX];
        tx_en_out = ovr_in[SPP_FLD_TX];
      end else begin
        tx_en_out = ovr_in[SPP_FLD_BP];
      end
    end else if (!an_complete_in) begin
      rx_en_out = 1'h0;
    end else if (!lp_an_able_in || !full_duplex_in) begin
      tx_en_out = ovr_in[SPP_FLD_BP];
    end else begin
      if (abil[3] && abil[1]) begin
        rx_en_out = 1'h1;
        tx_en_out = 1'h1;
      end else if (abil == 4'h7) begin
        tx_en_out = 1'h1;
      end else if (abil == 4'hD) begin
        rx_en_out = 1'h1;
      end else begin
        rx_en_out = 1'h0;
      end
    end
  end

endmodule

// ==== logic/spp_link_timer.sv ====
// link-up qualification timer for one port
`timescale 1ns/100ps
module spp_link_timer
  import spp_pkg::*;
#(
  parameter int LINK_UP_CYC = SPP_LINK_UP_CYC
) (
  input wire logic clk_sys_in, // system clock
  input wire logic rst_in, // synchronous reset, active high
  input wire logic link_up_in, // phy link status
  output logic link_stable_out // link up for the full time
);

  typedef struct packed {
    logic [31:0] cnt;
    logic stable;
  } spp_timer_type;

  spp_timer_type st_r;
  spp_timer_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!link_up_in) begin
      st_nxt.cnt = 32'h0000_0000;
      st_nxt.stable = 1'h0;
    end else if (st_r.cnt >= 32'(LINK_UP_CYC - 1)) begin
      st_nxt.stable = 1'h1;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link_stable_out = st_r.stable;

endmodule

// ==== logic/spp_port_enables.sv ====
// top: per-port pause and low-power-idle enables with override registers
`timescale 1ns/100ps
// Behaviour
// - each of three ports gets separate transmit and receive pause enables
// - transmit enable means back pressure in half duplex, pause frames in full
// - receive enable lets received pause frames halt own transmission
// - port0 uses virtual phy0, port1 phy A or virtual phy1, port2 phy B
// - half duplex: receive off, transmit follows back-pressure bit
// - manual path in full duplex uses manual receive and transmit bits
// - negotiated full duplex resolves enables from pause abilities
// - negotiating and not yet complete: both enables off
// - partner cannot negotiate: half duplex handling, back-pressure bit
// - local and partner symmetric pause: both enables on
// - local asym only, partner both: transmit on, receive off
// - local both, partner asym only: receive on, transmit off
// - all other negotiated combinations: both enables off
// - override settings never touch advertised pause bits
// - virtual phy ports swap local and partner ability inputs
// - override register reads back active duplex and enables
// - idle permitted only with enable bit, right mode, full; phy A/B ports also need 100M and both EEE
// - phy A/B ports also need link up continuously for one second
// - port0 permits idle only in mii mac, duplex from virtual phy
// - port1 permits in internal phy from phy A, or mii mac duplex only
// - port1 denies idle in mii phy and both rmii modes
// - port2 qualifiers all come from phy B
module spp_port_enables
  import spp_pkg::*;
#(
  parameter int LINK_UP_CYC = SPP_LINK_UP_CYC
) (
  input wire logic clk_sys_in, // system clock, 40 MHz
  input wire logic rst_in, // synchronous reset, active high
  // register port
  input wire logic [3:0] reg_addr_in, // register byte address
  input wire logic [SPP_REG_W-1:0] reg_wdata_in, // write data
  input wire logic reg_wr_in, // write strobe
  input wire logic reg_rd_in, // read strobe
  output logic [SPP_REG_W-1:0] reg_rdata_out, // read data, cycle after strobe
  // port modes
  input wire spp_mode_type p0_mode_in, // port0 mode
  input wire spp_mode_type p1_mode_in, // port1 mode
  // virtual phy 0
  input wire logic vp0_full_in, // full duplex
  input wire logic vp0_an_en_in, // negotiation enabled
  input wire logic vp0_an_done_in, // negotiation complete
  input wire logic vp0_lp_able_in, // partner can negotiate
  input wire logic [1:0] vp0_adv_in, // advertised {pause, asym}
  input wire logic [1:0] vp0_lpa_in, // partner ability {pause, asym}
  // virtual phy 1
  input wire logic vp1_full_in, // full duplex
  input wire logic vp1_an_en_in, // negotiation enabled
  input wire logic vp1_an_done_in, // negotiation complete
  input wire logic vp1_lp_able_in, // partner can negotiate
  input wire logic [1:0] vp1_adv_in, // advertised {pause, asym}
  input wire logic [1:0] vp1_lpa_in, // partner ability {pause, asym}
  // physical phy A
  input wire logic pa_full_in, // full duplex
  input wire logic pa_an_en_in, // negotiation enabled
  input wire logic pa_an_done_in, // negotiation complete
  input wire logic pa_lp_able_in, // partner can negotiate
  input wire logic [1:0] pa_adv_in, // advertised {pause, asym}
  input wire logic [1:0] pa_lpa_in, // partner ability {pause, asym}
  input wire logic pa_speed100_in, // 100 Mbps
  input wire logic pa_link_in, // link up
  input wire logic pa_eee100_in, // both ends negotiated EEE 100M
  // physical phy B
  input wire logic pb_full_in, // full duplex
  input wire logic pb_an_en_in, // negotiation enabled
  input wire logic pb_an_done_in, // negotiation complete
  input wire logic pb_lp_able_in, // partner can negotiate
  input wire logic [1:0] pb_adv_in, // advertised {pause, asym}
  input wire logic [1:0] pb_lpa_in, // partner ability {pause, asym}
  input wire logic pb_speed100_in, // 100 Mbps
  input wire logic pb_link_in, // link up
  input wire logic pb_eee100_in, // both ends negotiated EEE 100M
  // results
  output logic [SPP_NUM_PORTS-1:0] tx_pause_en_out, // tx flow control per port
  output logic [SPP_NUM_PORTS-1:0] rx_pause_en_out, // rx flow control per port
  output logic [SPP_NUM_PORTS-1:0] lpi_permit_out // low-power-idle permission
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SPP_REG_W-1:0] ovr0;
    logic [SPP_REG_W-1:0] ovr1;
    logic [SPP_REG_W-1:0] ovr2;
    logic [SPP_REG_W-1:0] rdata;
    logic [SPP_NUM_PORTS-1:0] tx;
    logic [SPP_NUM_PORTS-1:0] rx;
    logic [SPP_NUM_PORTS-1:0] lpi;
  } spp_state_type;

  spp_state_type st_r;
  spp_state_type st_nxt;

  // ----------------------------------------------------------------
  // per-port phy selection
  // ----------------------------------------------------------------
  logic p1_int;
  logic [SPP_NUM_PORTS-1:0] full;
  logic [SPP_NUM_PORTS-1:0] an_en;
  logic [SPP_NUM_PORTS-1:0] an_done;
  logic [SPP_NUM_PORTS-1:0] lp_able;
  logic [1:0] loc_ab [SPP_NUM_PORTS];
  logic [1:0] lp_ab [SPP_NUM_PORTS];
  logic [SPP_NUM_PORTS-1:0] rx_res;
  logic [SPP_NUM_PORTS-1:0] tx_res;
  logic pa_stable;
  logic pb_stable;

  always_comb begin
    p1_int = (p1_mode_in == SPP_MODE_INT_PHY);
    // port 0 from virtual phy 0
    full[0] = vp0_full_in;
    an_en[0] = vp0_an_en_in;
    an_done[0] = vp0_an_done_in;
    lp_able[0] = vp0_lp_able_in;
    // virtual phy faces the mac, so its view is mirrored
    loc_ab[0] = vp0_lpa_in;
    lp_ab[0] = vp0_adv_in;
    // port 1 from phy A or virtual phy 1
    if (p1_int) begin
      full[1] = pa_full_in;
      an_en[1] = pa_an_en_in;
      an_done[1] = pa_an_done_in;
      lp_able[1] = pa_lp_able_in;
      loc_ab[1] = pa_adv_in;
      lp_ab[1] = pa_lpa_in;
    end else begin
      full[1] = vp1_full_in;
      an_en[1] = vp1_an_en_in;
      an_done[1] = vp1_an_done_in;
      lp_able[1] = vp1_lp_able_in;
      loc_ab[1] = vp1_lpa_in;
      lp_ab[1] = vp1_adv_in;
    end
    // port 2 from phy B
    full[2] = pb_full_in;
    an_en[2] = pb_an_en_in;
    an_done[2] = pb_an_done_in;
    lp_able[2] = pb_lp_able_in;
    loc_ab[2] = pb_adv_in;
    lp_ab[2] = pb_lpa_in;
  end

  // ----------------------------------------------------------------
  // pause resolution, one per port
  // ----------------------------------------------------------------
  // advertisement bits are inputs only; overrides cannot reach them
  for (genvar g = 0; g < SPP_NUM_PORTS; g++) begin : g_res
    spp_pause_resolve u_res (
      .full_duplex_in(full[g]),
      .an_enable_in(an_en[g]),
      .an_complete_in(an_done[g]),
      .lp_an_able_in(lp_able[g]),
      .loc_pause_in(loc_ab[g][1]),
      .loc_asym_in(loc_ab[g][0]),
      .lp_pause_in(lp_ab[g][1]),
      .lp_asym_in(lp_ab[g][0]),
      .ovr_in(spp_ovr_of(st_r, g)),
      .rx_en_out(rx_res[g]),
      .tx_en_out(tx_res[g])
    );
  end

  // ----------------------------------------------------------------
  // link stability timers for physical phys
  // ----------------------------------------------------------------
  // mii mac ports see no link status, so only the physical phys need one
  spp_link_timer #(
    .LINK_UP_CYC(LINK_UP_CYC)
  ) u_tmr_a (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .link_up_in(pa_link_in),
    .link_stable_out(pa_stable)
  );

  spp_link_timer #(
    .LINK_UP_CYC(LINK_UP_CYC)
  ) u_tmr_b (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .link_up_in(pb_link_in),
    .link_stable_out(pb_stable)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // status bits overlay the stored control bits on readback
  function automatic logic [SPP_REG_W-1:0] spp_status(
    input logic [SPP_REG_W-1:0] ovr,
    input logic dup,
    input logic rx,
    input logic tx
  );
    logic [SPP_REG_W-1:0] v;
    v = ovr;
    v[SPP_FLD_DUPLEX_ST] = dup;
    v[SPP_FLD_RX_ST] = rx;
    v[SPP_FLD_TX_ST] = tx;
    return v;
  endfunction

  // only control bits are writable
  function automatic logic [SPP_REG_W-1:0] spp_write(input logic [SPP_REG_W-1:0] d);
    logic [SPP_REG_W-1:0] v;
    v = '0;
    v[SPP_FLD_LPI:SPP_FLD_BP] = d[SPP_FLD_LPI:SPP_FLD_BP];
    return v;
  endfunction

  // override register of one port
  function automatic logic [SPP_REG_W-1:0] spp_ovr_of(
    input spp_state_type s,
    input int p
  );
    logic [SPP_REG_W-1:0] v;
    case (p)
      0: begin
        v = s.ovr0;
      end
      1: begin
        v = s.ovr1;
      end
      default: begin
        v = s.ovr2;
      end
    endcase
    return v;
  endfunction

  // physical phy path: every qualifier plus the link timer
  function automatic logic spp_lpi_phy(
    input logic en,
    input logic speed100,
    input logic dup,
    input logic eee100,
    input logic stable
  );
    return en && speed100 && dup && eee100 && stable;
  endfunction

  // mii mac path: speed, link and negotiation are invisible there
  function automatic logic spp_lpi_virt(
    input logic en,
    input logic dup
  );
    return en && dup;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // registered enables feed the port mac
    st_nxt.tx = tx_res;
    st_nxt.rx = rx_res;

    // port 0: mii mac only, duplex from virtual phy
    st_nxt.lpi[0] = (p0_mode_in == SPP_MODE_MII_MAC) &&
                    spp_lpi_virt(st_r.ovr0[SPP_FLD_LPI], vp0_full_in);
    // port 1: internal phy uses phy A qualifiers, mii mac duplex only
    if (p1_int) begin
      st_nxt.lpi[1] = spp_lpi_phy(st_r.ovr1[SPP_FLD_LPI], pa_speed100_in, pa_full_in,
                                  pa_eee100_in, pa_stable);
    end else if (p1_mode_in == SPP_MODE_MII_MAC) begin
      st_nxt.lpi[1] = spp_lpi_virt(st_r.ovr1[SPP_FLD_LPI], vp1_full_in);
    end else begin
      st_nxt.lpi[1] = 1'h0;
    end
    // port 2: everything from phy B
    st_nxt.lpi[2] = spp_lpi_phy(st_r.ovr2[SPP_FLD_LPI], pb_speed100_in, pb_full_in,
                                pb_eee100_in, pb_stable);

    // register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        SPP_ADDR_P0: begin
          st_nxt.ovr0 = spp_write(reg_wdata_in);
        end
        SPP_ADDR_P1: begin
          st_nxt.ovr1 = spp_write(reg_wdata_in);
        end
        SPP_ADDR_P2: begin
          st_nxt.ovr2 = spp_write(reg_wdata_in);
        end
        default: begin
          st_nxt.ovr0 = st_r.ovr0;
        end
      endcase
    end

    // read data valid only in the cycle after the strobe
    st_nxt.rdata = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        SPP_ADDR_P0: begin
          st_nxt.rdata = spp_status(st_r.ovr0, full[0], st_r.rx[0], st_r.tx[0]);
        end
        SPP_ADDR_P1: begin
          st_nxt.rdata = spp_status(st_r.ovr1, full[1], st_r.rx[1], st_r.tx[1]);
        end
        SPP_ADDR_P2: begin
          st_nxt.rdata = spp_status(st_r.ovr2, full[2], st_r.rx[2], st_r.tx[2]);
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_r.ovr0 <= SPP_OVR_RESET;
      st_r.ovr1 <= SPP_OVR_RESET;
      st_r.ovr2 <= SPP_OVR_RESET;
      st_r.rdata <= '0;
      st_r.tx <= '0;
      st_r.rx <= '0;
      st_r.lpi <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a register bit, no logic after the flops
  assign reg_rdata_out = st_r.rdata;
  assign tx_pause_en_out = st_r.tx;
  assign rx_pause_en_out = st_r.rx;
  assign lpi_permit_out = st_r.lpi;

endmodule

// ==== testbench/spp_phy_model.sv ====
// status model of the four phys facing the switch ports
`timescale 1ns/100ps
module spp_phy_model (
  input wire logic clk_sys_in, // system clock
  input wire logic [3:0][10:0] want_in, // requested status per phy
  output logic [3:0][10:0] status_out // presented status per phy
);
  // word: full, an_en, an_done, lp_able, adv[1:0], lpa[1:0], speed100, link, eee100
  // advertisement passes as set, never touched by any override
  always_ff @(posedge clk_sys_in) begin
    status_out <= want_in;
  end
endmodule

// ==== testbench/spp_port_enables_asserts.sv ====
// concurrent checks on port 2 pause and idle enables
`timescale 1ns/100ps
module spp_port_enables_asserts
  import spp_pkg::*;
#(
  parameter int LINK_UP_CYC = SPP_LINK_UP_CYC
) (
  input wire logic clk_sys_in, // clock
  input wire logic rst_in, // reset
  input wire logic [3:0] reg_addr_in, // address
  input wire logic [SPP_REG_W-1:0] reg_wdata_in, // write data
  input wire logic reg_wr_in, // write strobe
  input wire logic pb_full_in, // full duplex
  input wire logic pb_an_en_in, // an enabled
  input wire logic pb_an_done_in, // an done
  input wire logic pb_lp_able_in, // partner an able
  input wire logic [1:0] pb_adv_in, // local pause bits
  input wire logic [1:0] pb_lpa_in, // partner pause bits
  input wire logic pb_speed100_in, // 100M
  input wire logic pb_link_in, // link
  input wire logic pb_eee100_in, // eee 100M
  input wire logic [SPP_NUM_PORTS-1:0] tx_pause_en_out, // tx enables
  input wire logic [SPP_NUM_PORTS-1:0] rx_pause_en_out, // rx enables
  input wire logic [SPP_NUM_PORTS-1:0] lpi_permit_out // idle permission
);
  // ----
  // helper state
  // ----
  // shadow of the port 2 override, the register itself is not visible here
  logic [SPP_REG_W-1:0] ovr_r;
  int link_cnt_r;
  wire logic man = ovr_r[SPP_FLD_SEL] || !pb_an_en_in;
  wire logic neg = !man && pb_an_done_in && pb_lp_able_in && pb_full_in;
  wire logic half = (!pb_full_in && (man || pb_an_done_in)) ||
    (!man && pb_an_done_in && !pb_lp_able_in);
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ovr_r <= 8'h00;
      link_cnt_r <= 0;
    end else begin
      if (reg_wr_in && reg_addr_in == SPP_ADDR_P2) begin
        ovr_r <= reg_wdata_in;
      end
      link_cnt_r <= !pb_link_in ? 0 : (link_cnt_r < LINK_UP_CYC ? link_cnt_r + 1 : link_cnt_r);
    end
  end
  // ----
  // checks
  // ----
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  a_half_backpress: assert property (half |=> !rx_pause_en_out[2] &&
    tx_pause_en_out[2] == $past(ovr_r[SPP_FLD_BP])) else $error("half duplex enables wrong");
  a_manual_full: assert property (man && pb_full_in |=>
    rx_pause_en_out[2] == $past(ovr_r[SPP_FLD_RX]) &&
    tx_pause_en_out[2] == $past(ovr_r[SPP_FLD_TX])) else $error("manual enables wrong");
  a_an_pending: assert property (!man && !pb_an_done_in |=>
    !rx_pause_en_out[2] && !tx_pause_en_out[2]) else $error("enables on before an done");
  a_sym_pause: assert property (neg && pb_adv_in[1] && pb_lpa_in[1] |=>
    rx_pause_en_out[2] && tx_pause_en_out[2]) else $error("symmetric pause wrong");
  a_asym_tx: assert property (neg && pb_adv_in == 2'h1 && pb_lpa_in == 2'h3 |=>
    tx_pause_en_out[2] && !rx_pause_en_out[2]) else $error("asym tx pause wrong");
  a_asym_rx: assert property (neg && pb_adv_in == 2'h3 && pb_lpa_in == 2'h1 |=>
    rx_pause_en_out[2] && !tx_pause_en_out[2]) else $error("asym rx pause wrong");
  a_other_off: assert property (neg && !(pb_adv_in[1] && pb_lpa_in[1]) &&
    !(pb_adv_in == 2'h1 && pb_lpa_in == 2'h3) && !(pb_adv_in == 2'h3 && pb_lpa_in == 2'h1)
    |=> !rx_pause_en_out[2] && !tx_pause_en_out[2]) else $error("pause should be off");
  a_idle_qual: assert property (lpi_permit_out[2] |-> $past(ovr_r[SPP_FLD_LPI]) &&
    $past(pb_speed100_in) && $past(pb_eee100_in) && $past(pb_full_in))
    else $error("idle permitted without qualifiers");
  a_link_hold: assert property (lpi_permit_out[2] |->
    $past(link_cnt_r) >= LINK_UP_CYC) else $error("idle before link qualified");
  a_link_drop: assert property (!pb_link_in |-> ##2 !lpi_permit_out[2])
    else $error("idle kept after link drop");
  c_asym_rx: cover property (neg && pb_adv_in == 2'h3 && pb_lpa_in == 2'h1);
  c_pending: cover property (!man && !pb_an_done_in && pb_an_en_in);
  c_idle_on: cover property (lpi_permit_out[2]);
endmodule

bind spp_port_enables spp_port_enables_asserts #(.LINK_UP_CYC(LINK_UP_CYC)) chk_u (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .pb_full_in(pb_full_in),
  .pb_an_en_in(pb_an_en_in), .pb_an_done_in(pb_an_done_in), .pb_lp_able_in(pb_lp_able_in),
  .pb_adv_in(pb_adv_in), .pb_lpa_in(pb_lpa_in), .pb_speed100_in(pb_speed100_in),
  .pb_link_in(pb_link_in), .pb_eee100_in(pb_eee100_in), .tx_pause_en_out(tx_pause_en_out),
  .rx_pause_en_out(rx_pause_en_out), .lpi_permit_out(lpi_permit_out)
);

// ==== testbench/spp_port_enables_tb_top.sv ====
// self-checking bench for the port pause and idle enable block
`timescale 1ns/100ps
module spp_port_enables_tb_top
  import spp_pkg::*;
;
  localparam int LINK_CYC = 8;
  logic clk_sys_in = 1'h0;
  logic rst_in = 1'h1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'h0;
  logic reg_rd_in = 1'h0;
  logic [7:0] reg_rdata_out;
  spp_mode_type p0_mode_in = SPP_MODE_MII_MAC;
  spp_mode_type p1_mode_in = SPP_MODE_INT_PHY;
  logic [3:0][10:0] want = 44'h0;
  logic [3:0][10:0] st;
  logic [2:0] tx_o, rx_o, lpi_o;
  logic [7:0] v;
  logic [17:0] cases [14];
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  always #12.5 clk_sys_in = ~clk_sys_in;

  spp_phy_model phy_u (.clk_sys_in(clk_sys_in), .want_in(want), .status_out(st));

  spp_port_enables #(.LINK_UP_CYC(LINK_CYC)) dut_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .p0_mode_in(p0_mode_in), .p1_mode_in(p1_mode_in),
    .vp0_full_in(st[0][10]), .vp0_an_en_in(st[0][9]), .vp0_an_done_in(st[0][8]),
    .vp0_lp_able_in(st[0][7]), .vp0_adv_in(st[0][6:5]), .vp0_lpa_in(st[0][4:3]),
    .vp1_full_in(st[1][10]), .vp1_an_en_in(st[1][9]), .vp1_an_done_in(st[1][8]),
    .vp1_lp_able_in(st[1][7]), .vp1_adv_in(st[1][6:5]), .vp1_lpa_in(st[1][4:3]),
    .pa_full_in(st[2][10]), .pa_an_en_in(st[2][9]), .pa_an_done_in(st[2][8]),
    .pa_lp_able_in(st[2][7]), .pa_adv_in(st[2][6:5]), .pa_lpa_in(st[2][4:3]),
    .pa_speed100_in(st[2][2]), .pa_link_in(st[2][1]), .pa_eee100_in(st[2][0]),
    .pb_full_in(st[3][10]), .pb_an_en_in(st[3][9]), .pb_an_done_in(st[3][8]),
    .pb_lp_able_in(st[3][7]), .pb_adv_in(st[3][6:5]), .pb_lpa_in(st[3][4:3]),
    .pb_speed100_in(st[3][2]), .pb_link_in(st[3][1]), .pb_eee100_in(st[3][0]),
    .tx_pause_en_out(tx_o), .rx_pause_en_out(rx_o), .lpi_permit_out(lpi_o));

  // ----
  // tasks
  // ----
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'h1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'h1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'h0;
    @(negedge clk_sys_in);
    v = reg_rdata_out;
  endtask
  task automatic wr_all(input logic [7:0] d);
    for (int p = 0; p < 3; p++) begin
      wr(4'(p * 4), d);
    end
  endtask
  // case word: {full, an_en, an_done, lp_able}, local, partner, override, {rx, tx}
  task automatic run_case(input logic [17:0] c);
    @(posedge clk_sys_in);
    // virtual phys present local and partner fields swapped
    want <= {{c[17:14], c[13:12], c[11:10], 3'h0}, {c[17:14], c[13:12], c[11:10], 3'h0},
      {c[17:14], c[11:10], c[13:12], 3'h0}, {c[17:14], c[11:10], c[13:12], 3'h0}};
    wr_all(c[9:2]);
    wt(3);
    chk({tx_o, rx_o}, {{3{c[0]}}, {3{c[1]}}});
    for (int p = 0; p < 3; p++) begin
      rd(4'(p * 4));
      chk(v, {c[0], c[1], c[17], c[6:2]});
    end
  endtask

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      final_report();
    end
  end

  // ----
  // sequence
  // ----
  initial begin
    cases = '{
      {4'h7, 2'h0, 2'h0, 8'h09, 2'h1},
      {4'h8, 2'h0, 2'h0, 8'h02, 2'h2},
      {4'hF, 2'h3, 2'h3, 8'h0C, 2'h1},
      {4'hD, 2'h3, 2'h3, 8'h07, 2'h0},
      {4'hE, 2'h0, 2'h0, 8'h01, 2'h1},
      {4'h7, 2'h0, 2'h0, 8'h01, 2'h1},
      {4'hF, 2'h2, 2'h2, 8'h00, 2'h3},
      {4'hF, 2'h1, 2'h3, 8'h00, 2'h1},
      {4'hF, 2'h3, 2'h1, 8'h00, 2'h2},
      {4'hF, 2'h0, 2'h3, 8'h17, 2'h0},
      {4'hF, 2'h1, 2'h1, 8'h17, 2'h0},
      {4'hF, 2'h1, 2'h2, 8'h17, 2'h0},
      {4'hF, 2'h2, 2'h1, 8'h17, 2'h0},
      {4'hF, 2'h3, 2'h0, 8'h17, 2'h0}};
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    @(negedge clk_sys_in);
    chk({tx_o, rx_o}, 8'h00);
    rd(4'h2);
    chk(v, 8'h00);
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys_in);
      p1_mode_in <= (m != 0) ? SPP_MODE_MII_MAC : SPP_MODE_INT_PHY;
      foreach (cases[i]) begin
        run_case(cases[i]);
      end
    end
    @(posedge clk_sys_in);
    p1_mode_in <= SPP_MODE_INT_PHY;
    wr_all(8'h10);
    @(posedge clk_sys_in);
    want <= {4{11'h407}};
    wt(4);
    chk(lpi_o, 8'h01);
    wt(10);
    chk(lpi_o, 8'h07);
    @(posedge clk_sys_in);
    want[3] <= 11'h405;
    @(posedge clk_sys_in);
    want[3] <= 11'h407;
    wt(4);
    chk(lpi_o, 8'h03);
    wt(12);
    chk(lpi_o, 8'h07);
    @(posedge clk_sys_in);
    want[2] <= 11'h406;
    want[3] <= 11'h403;
    wt(4);
    chk(lpi_o, 8'h01);
    @(posedge clk_sys_in);
    want[2] <= 11'h407;
    for (int m = 2; m < 5; m++) begin
      @(posedge clk_sys_in);
      p0_mode_in <= spp_mode_type'(m);
      p1_mode_in <= spp_mode_type'(m);
      wt(3);
      chk(lpi_o, 8'h00);
    end
    @(posedge clk_sys_in);
    p0_mode_in <= SPP_MODE_MII_MAC;
    p1_mode_in <= SPP_MODE_MII_MAC;
    want[2] <= 11'h000;
    wt(3);
    chk(lpi_o, 8'h03);
    @(posedge clk_sys_in);
    want[1] <= 11'h007;
    wt(3);
    chk(lpi_o, 8'h01);
    wr(SPP_ADDR_P0, 8'h00);
    wt(3);
    chk(lpi_o, 8'h00);
    final_report();
  end
endmodule
